// >>> src/smd_pkg.sv
// package for the stepper driver serial control port
// assumes a 100 MHz system clock and a 6 ns-class serial link clock
`default_nettype none
package smd_pkg;
    localparam int WORD_BITS     = 12;
    localparam int CNT_W         = 5;
    localparam int DAC_W         = 4;
    localparam int BIT_A_DECAY   = 11;
    localparam int BIT_A_MAG_HI  = 10;
    localparam int BIT_A_MAG_LO  = 7;
    localparam int BIT_A_POL     = 6;
    localparam int BIT_B_DECAY   = 5;
    localparam int BIT_B_MAG_HI  = 4;
    localparam int BIT_B_MAG_LO  = 1;
    localparam int BIT_B_POL     = 0;
    localparam int CLK_MHZ       = 100;
    localparam int PD_TYP_US     = 3;
    localparam int PD_TYP_CYC    = PD_TYP_US * CLK_MHZ;
    localparam int OSC_DIV_DEF   = 4000;
    localparam logic [DAC_W-1:0] DAC_OFF = 4'h0;
    localparam logic [WORD_BITS-1:0] WORD_RST = 12'h000;

    typedef struct packed {
        logic             mixedDecay;
        logic [DAC_W-1:0] magnitude;
        logic             polarity;
    } smd_phase_t;

    typedef struct packed {
        smd_phase_t phaseA;
        smd_phase_t phaseB;
    } smd_word_t;

    typedef struct packed {
        logic highOn;
        logic lowOn;
        logic polarity;
    } smd_bridge_t;
endpackage
`default_nettype wire

// >>> src/smd_shift_in.sv
// serial shift register on the link clock
// assumes serialClk is the master's clock, only running while selected
`default_nettype none
module smd_shift_in
    import smd_pkg::*;
(
    input  wire logic                 serialClk,
    input  wire logic                 select_n,
    input  wire logic                 serial_in,
    output logic [WORD_BITS-1:0]      shiftWord,
    output logic [CNT_W-1:0]          bitCount,
    output logic                      serialBit
);
    logic [WORD_BITS-1:0] shift_r;
    logic [CNT_W-1:0]     count_r;
    logic                 sout_r;
    logic                 clrSeen_r;

    // count restarts on the first edge of a new frame
    always_ff @(posedge serialClk or posedge select_n) begin
        if (select_n) begin
            clrSeen_r <= 1'b1;
        end else begin
            clrSeen_r <= 1'b0;
        end
    end

    always_ff @(posedge serialClk) begin
        if (!select_n) begin
            shift_r <= {shift_r[WORD_BITS-2:0], serial_in}; // RULE11 RULE2
            count_r <= clrSeen_r ? CNT_W'(1)
                     : (count_r == {CNT_W{1'b1}} ? count_r : count_r + CNT_W'(1));
        end
    end

    // msb leaves on the falling edge so the next device in a chain samples it
    always_ff @(negedge serialClk) begin
        sout_r <= shift_r[WORD_BITS-1]; // RULE1
    end

    assign shiftWord = shift_r;
    assign bitCount  = count_r;
    assign serialBit = sout_r;
endmodule
`default_nettype wire

// >>> src/smd_chopper.sv
// one bridge chopper: fixed period, off-time on sense trip
// assumes senseSync is already synchronised to clk
`default_nettype none
module smd_chopper
    import smd_pkg::*;
#(
    parameter int OSC_DIV = OSC_DIV_DEF
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             restart,
    input  wire logic             enable,
    input  wire smd_phase_t       setting,
    input  wire logic             senseSync,
    output smd_bridge_t           bridge
);
    localparam int DW = $clog2(OSC_DIV + 1);
    logic [DW-1:0] div_r;
    logic          on_r;
    logic          pol_r;
    wire           periodStart = restart || (div_r == DW'(OSC_DIV - 1));
    wire           coilOff     = (setting.magnitude == DAC_OFF) || !enable;

    always_ff @(posedge clk) begin
        if (rst) begin
            div_r <= '0;
            on_r  <= 1'b0;
            pol_r <= 1'b0;
        end else begin
            div_r <= periodStart ? '0 : div_r + DW'(1); // RULE5
            if (periodStart) begin
                pol_r <= setting.polarity;
                on_r  <= !senseSync && !coilOff; // RULE6 RULE8
            end else if (senseSync || coilOff) begin
                on_r  <= 1'b0; // RULE8
            end
        end
    end

    // slow decay keeps low side on, mixed decay drops both when chopping off
    always_ff @(posedge clk) begin
        if (rst) begin
            bridge <= '0;
        end else begin
            bridge.polarity <= pol_r;
            bridge.highOn   <= on_r;
            bridge.lowOn    <= !coilOff && (on_r || !setting.mixedDecay);
        end
    end
endmodule
`default_nettype wire

// >>> src/smd_serial_port.sv
// Summary of operation
// RULE1: serial out feeds next device for chaining; own select also works.
// RULE2: sixteen-bit frames work; top four bits simply shift out unused.
// RULE3: frames under twelve clocks are discarded, settings unchanged.
// RULE4: serial out high impedance while deselected or driver disabled.
// RULE5: polarity change restarts only that phase's chopper.
// RULE6: sense tripped at period start keeps bridge off that period.
// RULE7: polarity reaches outputs within one chopper period plus four us.
// RULE8: zero current field switches the coil fully off.
// RULE9: word bits map to decay, magnitude, polarity per phase.
// RULE10: host puts inverted extra current bits in top four; external use.
// RULE11: bits shift while selected; last twelve applied on select rising.
//
// top of the serial control port: link domain shift, system domain apply
// assumes serialClk stops between frames; select_n is held stable around it
`default_nettype none
module smd_serial_port
    import smd_pkg::*;
#(
    parameter int OSC_DIV = OSC_DIV_DEF
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        serialClk,
    input  wire logic        select_n,
    input  wire logic        serial_in,
    input  wire logic        driver_enable_n,
    input  wire logic        phase_a_sense_input,
    input  wire logic        phase_b_sense_input,
    output logic             serial_out,
    output logic             serialOutEn,
    output smd_bridge_t      phase_a_bridge_outputs,
    output smd_bridge_t      phase_b_bridge_outputs,
    output logic             phase_a_mixed_decay,
    output logic             phase_b_mixed_decay,
    output logic             phase_a_polarity,
    output logic             phase_b_polarity,
    output logic [DAC_W-1:0] phaseAMagnitude,
    output logic [DAC_W-1:0] phaseBMagnitude
);
    if (OSC_DIV < 2) begin : g_badDiv
        $error("OSC_DIV too small");
    end

    logic [WORD_BITS-1:0] shiftWord;
    logic [CNT_W-1:0]     bitCount;
    logic                 serialBit;

    smd_shift_in u_shift (
        .serialClk (serialClk),
        .select_n  (select_n),
        .serial_in (serial_in),
        .shiftWord (shiftWord),
        .bitCount  (bitCount),
        .serialBit (serialBit)
    );

    // select and async inputs through two flops before any system clock logic
    logic [1:0] selSync_r;
    logic [1:0] enSync_r;
    logic [1:0] senseA_r;
    logic [1:0] senseB_r;
    logic       selPrev_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            selSync_r <= 2'b11;
            enSync_r  <= 2'b11;
            senseA_r  <= 2'b00;
            senseB_r  <= 2'b00;
            selPrev_r <= 1'b1;
        end else begin
            selSync_r <= {selSync_r[0], select_n};
            enSync_r  <= {enSync_r[0], driver_enable_n};
            senseA_r  <= {senseA_r[0], phase_a_sense_input};
            senseB_r  <= {senseB_r[0], phase_b_sense_input};
            selPrev_r <= selSync_r[1];
        end
    end

    // shift word and count are stable once select is high and the clock stopped
    wire selRise   = selSync_r[1] && !selPrev_r;
    wire longEnough = bitCount >= CNT_W'(WORD_BITS);
    wire applyWord = selRise && longEnough; // RULE11 RULE3

    smd_word_t word_r;
    smd_word_t newWord;
    assign newWord.phaseA.mixedDecay = shiftWord[BIT_A_DECAY]; // RULE9
    assign newWord.phaseA.magnitude  = shiftWord[BIT_A_MAG_HI:BIT_A_MAG_LO];
    assign newWord.phaseA.polarity   = shiftWord[BIT_A_POL];
    assign newWord.phaseB.mixedDecay = shiftWord[BIT_B_DECAY];
    assign newWord.phaseB.magnitude  = shiftWord[BIT_B_MAG_HI:BIT_B_MAG_LO];
    assign newWord.phaseB.polarity   = shiftWord[BIT_B_POL];

    wire restartA = applyWord && (newWord.phaseA.polarity != word_r.phaseA.polarity); // RULE5
    wire restartB = applyWord && (newWord.phaseB.polarity != word_r.phaseB.polarity); // RULE5

    always_ff @(posedge clk) begin
        if (rst) begin
            word_r <= smd_word_t'(WORD_RST);
        end else if (applyWord) begin
            word_r <= newWord; // RULE3
        end
    end

    // restart one cycle after apply so the chopper latches the new polarity
    logic restartA_r;
    logic restartB_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            restartA_r <= 1'b0;
            restartB_r <= 1'b0;
        end else begin
            restartA_r <= restartA; // RULE5
            restartB_r <= restartB; // RULE5
        end
    end

    wire enabled = !enSync_r[1];

    // restart on apply gives polarity within a few cycles, well inside the bound
    smd_chopper #(.OSC_DIV(OSC_DIV)) u_chopA (
        .clk       (clk),
        .rst       (rst),
        .restart   (restartA_r), // RULE7
        .enable    (enabled),
        .setting   (word_r.phaseA),
        .senseSync (senseA_r[1]),
        .bridge    (phase_a_bridge_outputs)
    );

    smd_chopper #(.OSC_DIV(OSC_DIV)) u_chopB (
        .clk       (clk),
        .rst       (rst),
        .restart   (restartB_r), // RULE7
        .enable    (enabled),
        .setting   (word_r.phaseB),
        .senseSync (senseB_r[1]),
        .bridge    (phase_b_bridge_outputs)
    );

    assign phase_a_mixed_decay = word_r.phaseA.mixedDecay;
    assign phase_b_mixed_decay = word_r.phaseB.mixedDecay;
    assign phase_a_polarity    = word_r.phaseA.polarity;
    assign phase_b_polarity    = word_r.phaseB.polarity;
    assign phaseAMagnitude     = word_r.phaseA.magnitude;
    assign phaseBMagnitude     = word_r.phaseB.magnitude;

    // enable follows the raw pins so the pad releases immediately
    assign serial_out  = serialBit; // RULE1
    assign serialOutEn = !select_n && !driver_enable_n; // RULE4
endmodule
`default_nettype wire

// >>> dv/smd_port_props.sv
// checker for the serial control port, bound to its top
// assumes the system clock domain; link pins are seen as levels
`default_nettype none
module smd_port_chk
    import smd_pkg::*;
(
    input wire logic             clk,
    input wire logic             rst,
    input wire logic             select_n,
    input wire logic             driver_enable_n,
    input wire logic             phase_a_sense_input,
    input wire logic             serialOutEn,
    input wire smd_bridge_t      phase_a_bridge_outputs,
    input wire smd_bridge_t      phase_b_bridge_outputs,
    input wire logic             phase_a_polarity,
    input wire logic             phase_b_polarity,
    input wire logic [DAC_W-1:0] phaseAMagnitude,
    input wire logic [DAC_W-1:0] phaseBMagnitude
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence fieldMove;
        $changed({phaseAMagnitude, phaseBMagnitude, phase_a_polarity, phase_b_polarity});
    endsequence
    sequence senseHeld;
        phase_a_sense_input[*5];
    endsequence
    AST_OE_PINS: assert property (serialOutEn == (!select_n && !driver_enable_n))
        else $error("serial out enable does not follow select and enable");
    AST_OE_DISABLED: assert property (driver_enable_n |-> !serialOutEn)
        else $error("serial out driven while disabled");
    AST_APPLY_SEL: assert property (fieldMove |-> $past(select_n, 2) && select_n)
        else $error("fields moved while selected");
    AST_A_POL: assert property ($changed(phase_a_polarity)
        |-> ##[1:4] phase_a_bridge_outputs.polarity == phase_a_polarity)
        else $error("phase a bridge polarity late");
    AST_B_POL: assert property ($changed(phase_b_polarity)
        |-> ##[1:4] phase_b_bridge_outputs.polarity == phase_b_polarity)
        else $error("phase b bridge polarity late");
    AST_A_OFF: assert property ((phaseAMagnitude == DAC_OFF)[*3]
        |-> !phase_a_bridge_outputs.highOn && !phase_a_bridge_outputs.lowOn)
        else $error("phase a coil on at zero current");
    AST_B_OFF: assert property ((phaseBMagnitude == DAC_OFF)[*3]
        |-> !phase_b_bridge_outputs.highOn && !phase_b_bridge_outputs.lowOn)
        else $error("phase b coil on at zero current");
    AST_A_SENSE: assert property (senseHeld |-> !phase_a_bridge_outputs.highOn)
        else $error("phase a bridge on while sense tripped");
endmodule
bind smd_serial_port smd_port_chk smd_port_chk_inst (.clk, .rst, .select_n, .driver_enable_n,
    .phase_a_sense_input, .serialOutEn, .phase_a_bridge_outputs, .phase_b_bridge_outputs,
    .phase_a_polarity, .phase_b_polarity, .phaseAMagnitude, .phaseBMagnitude);
`default_nettype wire

// >>> dv/smd_host_model.sv
// host serial master model for the control port
// assumes the link clock idles low and runs only inside frames
`default_nettype none
module smd_host_model (
    output logic      serialClk,
    output logic      select_n,
    output logic      serial_in,
    input  wire logic serial_out,
    input  wire logic serialOutEn
);
    timeunit 1ns;
    timeprecision 100ps;
    logic chainBit;
    logic oeSeen;
    initial begin
        serialClk = 1'b0;
        select_n = 1'b0;
        serial_in = 1'b0;
        // one clean rising select edge so the frame counter starts known
        #1;
        select_n = 1'b1;
    end
    // top four bits carry the inverted extra current bits, if any
    task automatic send(input logic [15:0] w, input int n);
        select_n = 1'b0;
        #3.1;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = w[i];
            #3;
            serialClk = 1'b1;
            #3;
            serialClk = 1'b0;
        end
        #3;
        chainBit = serial_out;
        oeSeen = serialOutEn;
        select_n = 1'b1;
        serial_in = ~serial_in;
        #60;
    endtask
endmodule
`default_nettype wire

// >>> dv/tb.sv
// self-checking bench for the stepper driver serial control port
// assumes the host model drives the link; bench drives system-side pins
`default_nettype none
module tb
    import smd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic [15:0] w;
        logic [4:0]  n;
        logic [11:0] exp;
    } smd_row_t;
    logic             clk = 1'b0;
    logic             rst = 1'b1;
    logic             driver_enable_n = 1'b1;
    logic             senseA = 1'b0;
    logic             senseB = 1'b0;
    logic             serialClk, select_n, serial_in, serial_out, serialOutEn;
    logic             decA, decB, polA, polB;
    logic [DAC_W-1:0] magA, magB;
    smd_bridge_t      brA;
    smd_bridge_t      brB;
    int               n_mismatch = 0;
    int               checks_done = 0;
    wire [11:0]       gotWord = {decA, magA, polA, decB, magB, polB};
    smd_row_t rows [6] = '{'{16'h0ABC, 5'h0C, 12'hABC}, '{16'hF123, 5'h10, 12'h123},
        '{16'h0555, 5'h0B, 12'h123}, '{16'h0FFF, 5'h01, 12'h123},
        '{16'h0FBE, 5'h0C, 12'hFBE}, '{16'h0041, 5'h0C, 12'h041}};
    smd_serial_port #(.OSC_DIV(20)) smd_serial_port_inst (.clk, .rst, .serialClk, .select_n,
        .serial_in, .driver_enable_n, .phase_a_sense_input(senseA),
        .phase_b_sense_input(senseB), .serial_out, .serialOutEn,
        .phase_a_bridge_outputs(brA), .phase_b_bridge_outputs(brB),
        .phase_a_mixed_decay(decA), .phase_b_mixed_decay(decB), .phase_a_polarity(polA),
        .phase_b_polarity(polB), .phaseAMagnitude(magA), .phaseBMagnitude(magB));
    smd_host_model smd_host_model_inst (.serialClk, .select_n, .serial_in, .serial_out,
        .serialOutEn);
    always #5 clk = ~clk;
    task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic complete_run();
        $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #200us;
        n_mismatch++;
        complete_run();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        driver_enable_n <= 1'b0;
        repeat (3) @(negedge clk);
        check("reset word", WORD_RST, gotWord);
        foreach (rows[i]) begin
            smd_host_model_inst.send(rows[i].w, int'(rows[i].n));
            repeat (6) @(negedge clk);
            check("word", rows[i].exp, gotWord);
            if (rows[i].n >= 5'h0C)
                check("chain bit", {11'h000, rows[i].w[11]}, {11'h000, smd_host_model_inst.chainBit});
            check("frame enable", 12'h001, {11'h000, smd_host_model_inst.oeSeen});
        end
        check("zero current bridge", 12'h000, {10'h000, brA.highOn, brA.lowOn});
        @(posedge clk);
        driver_enable_n <= 1'b1;
        smd_host_model_inst.send(16'h0041, 12);
        check("disabled enable", 12'h000, {11'h000, smd_host_model_inst.oeSeen});
        @(posedge clk);
        driver_enable_n <= 1'b0;
        senseA <= 1'b1;
        smd_host_model_inst.send(16'h0FBE, 12);
        repeat (60) @(negedge clk);
        check("tripped high side", 12'h000, {11'h000, brA.highOn});
        check("bridge polarity", {11'h000, polA}, {11'h000, brA.polarity});
        check("bridge b polarity", {11'h000, polB}, {11'h000, brB.polarity});
        @(posedge clk);
        senseA <= 1'b0;
        repeat (45) @(negedge clk);
        check("released high side", 12'h001, {11'h000, brA.highOn});
        complete_run();
    end
endmodule
`default_nettype wire
